//--- src/ccwd_map.svh
`ifndef CCWD_MAP_SVH
`define CCWD_MAP_SVH

// command word field positions
`define CCWD_PAUSE_BIT 9
`define CCWD_BYP_BIT 8
`define CCWD_IST_HI 7
`define CCWD_IST_LO 6
`define CCWD_CHANNEL_SELECT_HI 5
`define CCWD_CHANNEL_SELECT_LO 0
`define CCWD_WORD_MASK 16'h03FF

// phase lengths in converter clocks
`define CCWD_INIT_CYC 8'h04
`define CCWD_XFER_CYC 8'h02
`define CCWD_RES_CYC 8'h0A
`define CCWD_BYP_MIN_FINAL 8'h04

// special channel codes
`define CCWD_CH_LOW_REF 6'h3C
`define CCWD_CH_HIGH_REF 6'h3D
`define CCWD_CH_HALF_SUP 6'h3E
`define CCWD_CH_EOQ 6'h3F
`define CCWD_CH_MA_FIRST 6'h34
`define CCWD_CH_MA_LAST 6'h36

`endif

//--- src/ccwd_pkg.sv
package ccwd_pkg;
  typedef enum logic [2:0] {
    CCWD_SRC_PIN_B,
    CCWD_SRC_PIN_A,
    CCWD_SRC_EXT_MUX,
    CCWD_SRC_LOW_REF,
    CCWD_SRC_HIGH_REF,
    CCWD_SRC_HALF_SUP
  } ccwd_src_e;

  typedef struct packed {
    ccwd_src_e src;
    logic [2:0] pin;
    logic [2:0] mux_addr;
    logic use_amp;
    logic end_of_queue;
  } ccwd_route_s;

  typedef struct packed {
    logic pause;
    logic amp_bypass;
    logic [1:0] sample_time_select;
    logic [5:0] channel_select;
  } ccwd_word_s;
endpackage

//--- src/ccwd_channel_select_decode.sv
`include "ccwd_map.svh"

module ccwd_channel_select_decode (
  // command fields
  input wire logic [5:0] channel_select_in,
  input wire logic ext_mux_mode_in,
  // decoded route
  output ccwd_pkg::ccwd_route_s route_out
);

  always_comb begin
    route_out = '0;
    route_out.src = ccwd_pkg::CCWD_SRC_LOW_REF;
    route_out.use_amp = 1'b1;
    if (channel_select_in[5:4] == 2'b11) begin
      if (channel_select_in >= `CCWD_CH_LOW_REF) begin
        route_out.use_amp = 1'b0;
        unique case (channel_select_in)
          `CCWD_CH_HIGH_REF: route_out.src = ccwd_pkg::CCWD_SRC_HIGH_REF;
          `CCWD_CH_HALF_SUP: route_out.src = ccwd_pkg::CCWD_SRC_HALF_SUP;
          `CCWD_CH_EOQ: route_out.end_of_queue = 1'b1;
          default: route_out.src = ccwd_pkg::CCWD_SRC_LOW_REF;
        endcase
      end else if (channel_select_in[3:2] == 2'b00) begin
        route_out.src = ccwd_pkg::CCWD_SRC_PIN_B;
        route_out.pin = {1'b1, channel_select_in[1:0]};
      end else if (ext_mux_mode_in &&
                   channel_select_in >= `CCWD_CH_MA_FIRST &&
                   channel_select_in <= `CCWD_CH_MA_LAST) begin
        route_out.src = ccwd_pkg::CCWD_SRC_LOW_REF;
      end else begin
        route_out.src = ccwd_pkg::CCWD_SRC_PIN_A;
        route_out.pin = 3'(channel_select_in - 6'h34);
      end
    end else if (channel_select_in[5] == 1'b0) begin
      if (ext_mux_mode_in) begin
        // bits 4 and 0 pick pin
        route_out.src = ccwd_pkg::CCWD_SRC_EXT_MUX;
        route_out.pin = {1'b0, channel_select_in[4], channel_select_in[0]};
        route_out.mux_addr = channel_select_in[3:1];
      end else if (channel_select_in[4:2] == 3'b000) begin
        route_out.src = ccwd_pkg::CCWD_SRC_PIN_B;
        route_out.pin = {1'b0, channel_select_in[1:0]};
      end
    end
    // reserved 32 to 47 fall to low ref
  end

endmodule

//--- src/ccwd_sequencer.sv
//**********************************************************
//**********************************************************
`include "ccwd_map.svh"

module ccwd_sequencer #(
  parameter int DEPTH = 40,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // command table write port and read data
  input wire logic cmd_we_in,
  input wire logic [AW-1:0] cmd_addr_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic [15:0] cmd_rdata_out,
  // queue control
  input wire logic trigger_in,
  input wire logic ext_mux_mode_in,
  input wire logic [AW-1:0] queue_start_in,
  input wire logic converter_clock_in,
  // converter datapath
  output ccwd_pkg::ccwd_route_s route_out,
  output logic sample_amp_out,
  output logic final_sample_out,
  output logic resolve_out,
  output logic conv_done_out,
  output logic [AW-1:0] word_ptr_out,
  // status
  output logic paused_out,
  output logic queue_done_out,
  output logic busy_out,
  // external mux address
  output logic [2:0] mux_addr_out,
  output logic [2:0] mux_addr_oe_out
);

  //********************************************************
  // command table
  //********************************************************
  logic [9:0] table_mem [DEPTH];
  logic [15:0] rdata_d, rdata_q;

  always_ff @(posedge core_clk_in) begin
    if (cmd_we_in && int'(cmd_addr_in) < DEPTH) begin
      table_mem[cmd_addr_in] <= cmd_wdata_in[9:0];
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (int'(cmd_addr_in) < DEPTH) begin
      rdata_d = {6'h00, table_mem[cmd_addr_in]} & `CCWD_WORD_MASK;
    end
  end

  //********************************************************
  // input sync and edge detect
  //********************************************************
  logic [2:0] trig_sync_q, converter_clock_sync_q;
  logic [2:0] trig_sync_d, converter_clock_sync_d;
  logic trig_evt, converter_clock_tick;

  always_comb begin
    trig_sync_d = {trig_sync_q[1:0], trigger_in};
    converter_clock_sync_d = {converter_clock_sync_q[1:0], converter_clock_in};
  end
  assign trig_evt = trig_sync_q[1] && !trig_sync_q[2];
  assign converter_clock_tick = converter_clock_sync_q[1] && !converter_clock_sync_q[2];

  //********************************************************
  // sequencer
  //********************************************************
  typedef enum logic [2:0] {
    CCWD_IDLE, CCWD_FETCH, CCWD_INIT, CCWD_XFER,
    CCWD_FINAL, CCWD_RESOLVE, CCWD_PAUSE
  } ccwd_state_e;

  ccwd_state_e state_q, state_d;
  logic [AW-1:0] ptr_q, ptr_d;
  logic [7:0] cnt_q, cnt_d;
  ccwd_pkg::ccwd_word_s word_q, word_d;
  logic done_q, done_d, qdone_q, qdone_d;
  ccwd_pkg::ccwd_route_s route;
  logic [7:0] final_cyc;
  logic last_word;

  ccwd_channel_select_decode u_decode (
    .channel_select_in(word_q.channel_select),
    .ext_mux_mode_in(ext_mux_mode_in),
    .route_out(route)
  );

  // 2 << code; longer window, longer conversion
  assign final_cyc = 8'(8'h02 << word_q.sample_time_select);
  assign last_word = (int'(ptr_q) + 1 >= DEPTH);

  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    word_d = word_q;
    done_d = 1'b0;
    qdone_d = 1'b0;
    unique case (state_q)
      CCWD_IDLE: begin
        if (trig_evt) begin
          ptr_d = queue_start_in;
          state_d = CCWD_FETCH;
        end
      end
      CCWD_FETCH: begin
        if (int'(ptr_q) >= DEPTH) begin
          qdone_d = 1'b1;
          state_d = CCWD_IDLE;
        end else begin
          word_d = ccwd_pkg::ccwd_word_s'(table_mem[ptr_q]);
          state_d = CCWD_INIT;
        end
      end
      CCWD_INIT: begin
        cnt_d = `CCWD_INIT_CYC;
        if (word_q.channel_select == `CCWD_CH_EOQ) begin
          qdone_d = 1'b1;
          state_d = CCWD_IDLE;
        end else if (word_q.amp_bypass || !route.use_amp) begin
          // internal levels go straight to the converter
          cnt_d = final_cyc;
          state_d = CCWD_FINAL;
        end else begin
          state_d = CCWD_XFER;
          cnt_d = `CCWD_INIT_CYC + `CCWD_XFER_CYC;
        end
      end
      CCWD_XFER: begin
        if (converter_clock_tick) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            cnt_d = final_cyc;
            state_d = CCWD_FINAL;
          end
        end
      end
      CCWD_FINAL: begin
        if (converter_clock_tick) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            cnt_d = `CCWD_RES_CYC;
            state_d = CCWD_RESOLVE;
          end
        end
      end
      CCWD_RESOLVE: begin
        if (converter_clock_tick) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            done_d = 1'b1;
            ptr_d = AW'(int'(ptr_q) + 1);
            if (last_word) begin
              qdone_d = 1'b1;
              state_d = CCWD_IDLE;
            end else if (word_q.pause) begin
              state_d = CCWD_PAUSE;
            end else begin
              state_d = CCWD_FETCH;
            end
          end
        end
      end
      CCWD_PAUSE: begin
        if (trig_evt) begin
          state_d = CCWD_FETCH;
        end
      end
      default: state_d = CCWD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= CCWD_IDLE;
      ptr_q <= '0;
      cnt_q <= 8'h00;
      word_q <= '0;
      done_q <= 1'b0;
      qdone_q <= 1'b0;
      rdata_q <= 16'h0000;
      trig_sync_q <= 3'h0;
      converter_clock_sync_q <= 3'h0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      done_q <= done_d;
      qdone_q <= qdone_d;
      rdata_q <= rdata_d;
      trig_sync_q <= trig_sync_d;
      converter_clock_sync_q <= converter_clock_sync_d;
    end
  end

  //********************************************************
  // outputs
  //********************************************************
  logic busy;
  assign busy = (state_q != CCWD_IDLE) && (state_q != CCWD_PAUSE);
  assign cmd_rdata_out = rdata_q;
  // route valid only while a word is active
  assign route_out = busy ? route : '0;
  assign sample_amp_out = (state_q == CCWD_XFER);
  assign final_sample_out = (state_q == CCWD_FINAL);
  assign resolve_out = (state_q == CCWD_RESOLVE);
  assign conv_done_out = done_q;
  assign queue_done_out = qdone_q;
  assign word_ptr_out = ptr_q;
  assign paused_out = (state_q == CCWD_PAUSE);
  assign busy_out = busy;
  // mux address pins driven in ext mux mode
  assign mux_addr_out = route.mux_addr;
  assign mux_addr_oe_out = {3{ext_mux_mode_in}};

endmodule

//--- dv/ccwd_checker.sv
module ccwd_checker #(
  parameter int DEPTH = 40,
  parameter int AW = 6
) (
  // clock, reset, table writes and mux mode
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic cmd_we_in,
  input wire logic [AW-1:0] cmd_addr_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic ext_mux_mode_in,
  // sequencer outputs
  input wire ccwd_pkg::ccwd_route_s route_out,
  input wire logic sample_amp_out,
  input wire logic final_sample_out,
  input wire logic conv_done_out,
  input wire logic [AW-1:0] word_ptr_out,
  input wire logic paused_out,
  input wire logic [2:0] mux_addr_oe_out
);
  // ****
  // shadow of the command table
  // ****
  logic [9:0] tbl_q [DEPTH];
  logic [AW-1:0] last_q;
  logic rs_q;
  logic [9:0] cw, dw;
  // the pointer has already moved on when the done pulse shows
  assign cw = tbl_q[word_ptr_out];
  assign dw = tbl_q[AW'(word_ptr_out - 1'b1)];
  always_ff @(posedge core_clk_in) begin
    if (cmd_we_in && cmd_addr_in < DEPTH) begin
      tbl_q[cmd_addr_in] <= cmd_wdata_in[9:0];
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_q <= '0;
      rs_q <= 1'b0;
    end else begin
      if (conv_done_out) last_q <= word_ptr_out;
      if (paused_out) rs_q <= 1'b1;
      else if (conv_done_out) rs_q <= 1'b0;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_park;
    ##[1:4] paused_out;
  endsequence
  a_pause_enter: assert property (
    conv_done_out && dw[9] && word_ptr_out != AW'(DEPTH) |-> s_park)
    else $error("pause word did not park the queue");
  a_no_pause: assert property (
    conv_done_out && !dw[9] |=> !paused_out)
    else $error("queue parked without pause bit");
  a_resume_next: assert property (
    conv_done_out && rs_q |-> word_ptr_out == last_q + 1'b1)
    else $error("resume did not take the following word");
  a_bypass_amp: assert property (
    final_sample_out && cw[8] |-> $past(!sample_amp_out, 2))
    else $error("bypassed word used the amplifier");
  a_special_amp: assert property (
    final_sample_out && cw[5:2] == 4'hf |-> !route_out.use_amp)
    else $error("special channel routed through amplifier");
  a_direct_pin: assert property (
    final_sample_out && !ext_mux_mode_in && cw[5:2] == 4'h0
    |-> route_out.src == ccwd_pkg::CCWD_SRC_PIN_B &&
    route_out.pin == cw[2:0])
    else $error("direct pin code misrouted");
  a_ext_channel_select: assert property (
    final_sample_out && ext_mux_mode_in && !cw[5]
    |-> route_out.src == ccwd_pkg::CCWD_SRC_EXT_MUX &&
    route_out.mux_addr == cw[3:1])
    else $error("external mux code misrouted");
  a_reserved_low: assert property (
    final_sample_out && cw[5:4] == 2'b10
    |-> route_out.src == ccwd_pkg::CCWD_SRC_LOW_REF)
    else $error("reserved code not on low reference");
  a_mux_oe: assert property (
    ext_mux_mode_in [*3] |-> mux_addr_oe_out == 3'b111)
    else $error("mux address lines not driven");
endmodule

bind ccwd_sequencer ccwd_checker #(.DEPTH(DEPTH), .AW(AW)) i_ccwd_checker (
  .core_clk_in, .rstn_in, .cmd_we_in, .cmd_addr_in, .cmd_wdata_in,
  .ext_mux_mode_in, .route_out, .sample_amp_out, .final_sample_out,
  .conv_done_out, .word_ptr_out, .paused_out, .mux_addr_oe_out);

//--- dv/ccwd_mux_model.sv
module ccwd_mux_model (
  // address lines and route from the sequencer
  input wire logic [2:0] mux_addr_in,
  input wire logic [2:0] mux_addr_oe_in,
  input wire ccwd_pkg::ccwd_route_s route_in,
  // channel that the mux chips pass through
  output logic [4:0] channel_select_out
);
  // ****
  // external multiplexer chips
  // ****
  // bank from port b pin, channel from address lines
  always_comb begin
    if (mux_addr_oe_in == 3'b111 && route_in.src == ccwd_pkg::CCWD_SRC_EXT_MUX)
      channel_select_out = {route_in.pin[1], mux_addr_in, route_in.pin[0]};
    else
      channel_select_out = 5'h1f;
  end
endmodule

//--- dv/test_conversion_command_word_decode.sv
module test_conversion_command_word_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, we = 0, trg = 0, ext = 0, qck = 0;
  logic [5:0] addr = '0, ptr;
  logic [15:0] wd = '0, rd;
  logic [2:0] ma, oe;
  logic cd, ps, qd, sa, fs, rs, bsy;
  logic [4:0] mch, mc;
  ccwd_pkg::ccwd_route_s rt, cap, e;
  int num_errors = 0, checks = 0, fin = 0, res = 0, amp = 0, qc = 0, qdn = 0;
  logic [15:0] w [11];
  logic [5:0] ct [11] = '{6'h01, 6'h11, 6'h28, 6'h31, 6'h35, 6'h3c, 6'h3d,
    6'h3e, 6'h06, 6'h3a, 6'h3f};
  int exq [$];
  logic [31:0] sd = 32'h15b8_86a6;
  ccwd_sequencer i_ccwd_sequencer (
    .core_clk_in(clk), .rstn_in(rstn), .cmd_we_in(we), .cmd_addr_in(addr),
    .cmd_wdata_in(wd), .cmd_rdata_out(rd), .trigger_in(trg),
    .ext_mux_mode_in(ext), .queue_start_in(6'h00),
    .converter_clock_in(qck), .route_out(rt), .sample_amp_out(sa),
    .final_sample_out(fs), .resolve_out(rs), .conv_done_out(cd),
    .word_ptr_out(ptr), .paused_out(ps), .queue_done_out(qd),
    .busy_out(bsy), .mux_addr_out(ma), .mux_addr_oe_out(oe));
  ccwd_mux_model i_ccwd_mux_model (
    .mux_addr_in(ma), .mux_addr_oe_in(oe), .route_in(rt), .channel_select_out(mch));
  // ****
  // model and checking
  // ****
  always #5 clk = ~clk;
  always @(posedge clk) begin
    qc <= (qc + 1) % 8;
    qck <= qc < 4;
  end
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic ccwd_pkg::ccwd_route_s exp_route(logic [5:0] c);
    ccwd_pkg::ccwd_route_s r;
    r = '0;
    r.src = ccwd_pkg::CCWD_SRC_LOW_REF;
    if (c == 6'h3d) r.src = ccwd_pkg::CCWD_SRC_HIGH_REF;
    else if (c == 6'h3e) r.src = ccwd_pkg::CCWD_SRC_HALF_SUP;
    else if (ext && c < 6'h20) r.src = ccwd_pkg::CCWD_SRC_EXT_MUX;
    else if (!ext && c < 6'h04 || c inside {[6'h30:6'h33]}) begin
      r.src = ccwd_pkg::CCWD_SRC_PIN_B;
      r.pin = {c[4], c[1:0]};
    end else if (c inside {[6'h34:6'h3b]} && !(ext && c < 6'h37)) begin
      r.src = ccwd_pkg::CCWD_SRC_PIN_A;
      r.pin = c[2:0] - 3'h4;
    end
    return r;
  endfunction
  task automatic chk(logic [15:0] s, logic [15:0] x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, x);
    end
  endtask
  task automatic check_conv();
    int i;
    i = exq.size() != 0 ? exq.pop_front() : 99;
    e = exp_route(w[i][5:0]);
    // done pulse shows the pointer already moved past the word
    chk(16'(ptr), 16'(i + 1));
    chk(16'(fin), 16'(2) << w[i][7:6]);
    chk(16'(res), 16'h000a);
    chk(16'(amp != 0), 16'(!w[i][8] && w[i][5:2] != 4'hf));
    chk(16'(cap.src), 16'(e.src));
    if (e.src < ccwd_pkg::CCWD_SRC_EXT_MUX) begin
      chk(16'(cap.pin), 16'(e.pin));
    end
    if (e.src == ccwd_pkg::CCWD_SRC_EXT_MUX) begin
      chk(16'(mc), 16'(w[i][4:0]));
    end
    fin = 0;
    res = 0;
    amp = 0;
  endtask
  // the synced tick lands in the qc == 3 cycle, so phase counts are exact
  // whatever the phase at which a bypassed word enters its final sample
  always @(posedge clk) begin
    if (qc == 3 && fs) fin++;
    if (qc == 3 && rs) res++;
    if (sa) amp++;
    if (fs) begin
      cap = rt;
      mc = mch;
    end
    if (qd) qdn++;
    if (cd) check_conv();
  end
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge clk) begin
      we <= 1;
      addr <= a;
      wd <= d;
    end
  endtask
  task automatic rdchk(logic [5:0] a, logic [15:0] x);
    @(posedge clk) addr <= a;
    @(posedge clk);
    @(posedge clk) chk(rd, {6'h00, x[9:0]});
  endtask
  task automatic run(int a, int b, logic p);
    int n;
    for (int i = a; i <= b; i++) exq.push_back(i);
    qdn = 0;
    @(posedge clk) trg <= 1;
    repeat (4) @(posedge clk);
    trg <= 0;
    n = 0;
    while (exq.size() != 0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000) num_errors++;
    repeat (6) @(posedge clk);
    chk(16'(ps), 16'(p));
    chk(16'(bsy), 16'h0000);
    chk(16'(qdn), 16'(!p));
  endtask
  task automatic results();
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #300us;
    num_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 11; i++) begin
      sd = lfsr(sd);
      // word 1 always bypasses so that path is never left to chance
      w[i] = {6'h00, i == 4, sd[2] || i == 1, sd[1:0], ct[i]};
      // bypassed words keep at least four final clocks
      if (w[i][8] && w[i][7:6] == 2'b00) w[i][7:6] = 2'b01;
      wr(6'(i), w[i] | 16'hfc00);
    end
    wr(6'h28, 16'hffff);
    @(posedge clk) we <= 0;
    rdchk(6'h03, w[3]);
    rdchk(6'h28, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      ext <= m[0];
      run(0, 4, 1);
      run(5, 9, 0);
    end
    results();
  end
endmodule
